//--- inc/efpc_pkg.sv
package efpc_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] EFPC_OFS_IRQ_EN_0   = 8'h04;
    localparam logic [7:0] EFPC_OFS_IRQ_EN_1   = 8'h05;
    localparam logic [7:0] EFPC_OFS_EVT_0      = 8'h06;
    localparam logic [7:0] EFPC_OFS_EVT_1      = 8'h07;
    localparam logic [7:0] EFPC_OFS_CLK_RX     = 8'h08;
    localparam logic [7:0] EFPC_OFS_LOOP_0     = 8'h0a;
    localparam logic [7:0] EFPC_OFS_LOOP_1     = 8'h0c;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] EFPC_RST_IRQ_EN     = 8'h00;
    localparam logic [7:0] EFPC_RST_EVT        = 8'h00;
    localparam logic [7:0] EFPC_RST_CLK_RX     = 8'h37;
    localparam logic [7:0] EFPC_RST_LOOP_0     = 8'h40;
    localparam logic [7:0] EFPC_RST_LOOP_1     = 8'hd1;

    // ------------------------------------------------------------
    // implemented bit masks of the flag registers
    // ------------------------------------------------------------
    localparam logic [7:0] EFPC_MSK_EVT_0      = 8'hf7;
    localparam logic [7:0] EFPC_MSK_EVT_1      = 8'h1c;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int EFPC_B_LOOP_LOST    = 7;
    localparam int EFPC_B_LOOP_LOCK    = 6;
    localparam int EFPC_B_SYNC_LOST    = 5;
    localparam int EFPC_B_SYNC_LOCK    = 4;
    localparam int EFPC_B_FIFO_ALIGNED = 2;
    localparam int EFPC_B_FIFO_WARN_1  = 1;
    localparam int EFPC_B_FIFO_WARN_2  = 0;
    localparam int EFPC_B_PAT_PASS     = 4;
    localparam int EFPC_B_PAT_FAIL_AC  = 3;
    localparam int EFPC_B_PAT_FAIL_ST  = 2;
    localparam int EFPC_B_CLK_DUTY     = 7;
    localparam int EFPC_B_REF_DUTY     = 6;
    localparam int EFPC_B_CLK_CROSS    = 5;
    localparam int EFPC_B_REF_CROSS    = 4;
    localparam int EFPC_B_LOOP_EN      = 7;
    localparam int EFPC_B_BAND_MANUAL  = 6;
    localparam int EFPC_B_BAND_HI      = 5;
    localparam int EFPC_B_BW_HI        = 7;
    localparam int EFPC_B_BW_LO        = 5;

    // ------------------------------------------------------------
    // timing counts
    // ------------------------------------------------------------
    localparam logic [3:0] EFPC_PAIRS_TO_CLEAR = 4'h8;

endpackage : efpc_pkg

//--- design/efpc_edge_det.sv
module efpc_edge_det
    import efpc_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    // level in, pulses out
    input  wire logic [1:0] level_i,
    output logic      [1:0] rise_o,
    output logic      [1:0] fall_o
);
    // ------------------------------------------------------------
    // edge detection of lock levels
    // ------------------------------------------------------------
    logic [1:0] level_ff;

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            level_ff <= 2'h0;
        end else begin
            level_ff <= level_i;
        end
    end

    // a loss is only reported after a lock was seen, so no fall at reset
    assign rise_o = level_i & ~level_ff;
    assign fall_o = ~level_i & level_ff;

endmodule : efpc_edge_det

//--- design/efpc_pat_clear.sv
module efpc_pat_clear
    import efpc_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rstn_i,
    // checker results per i/q pair
    input  wire logic pair_ok_i,
    input  wire logic pair_bad_i,
    // eight good pairs in a row
    output logic      run_done_o
);
    // ------------------------------------------------------------
    // consecutive good pair counter
    // ------------------------------------------------------------
    logic [3:0] run_ff;

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            run_ff <= 4'h0;
        end else if (pair_bad_i) begin
            run_ff <= 4'h0;
        end else if (pair_ok_i && run_ff != EFPC_PAIRS_TO_CLEAR) begin
            run_ff <= run_ff + 4'h1;
        end
    end

    // pulses once when the run reaches eight
    assign run_done_o = pair_ok_i && !pair_bad_i && (run_ff == EFPC_PAIRS_TO_CLEAR - 4'h1);

endmodule : efpc_pat_clear

//--- design/efpc_regs.sv
module efpc_regs
    import efpc_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    // register port (from serial port decoder)
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    // event sources
    input  wire logic       loop_locked_i,
    input  wire logic       sync_locked_i,
    input  wire logic       fifo_aligned_i,
    input  wire logic [1:0] fifo_distance_i,
    input  wire logic       pair_ok_i,
    input  wire logic       pair_bad_i,
    // controls
    output logic            clk_duty_corr_o,
    output logic            ref_duty_corr_o,
    output logic            clk_cross_corr_o,
    output logic            ref_cross_corr_o,
    output logic      [3:0] clk_rx_trim_o,
    output logic            loop_enable_o,
    output logic            band_manual_o,
    output logic      [5:0] loop_oscillator_band_o,
    output logic      [2:0] loop_bandwidth_o,
    output logic      [4:0] loop_trim_o,
    // interrupt
    output logic            irq_o
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] irq_en_0_ff;
    logic [7:0] irq_en_1_ff;
    logic [7:0] evt_0_ff;
    logic [7:0] evt_1_ff;
    logic [7:0] clk_rx_ff;
    logic [7:0] loop_0_ff;
    logic [7:0] loop_1_ff;
    logic [7:0] rdata_ff;
    logic       irq_ff;
    logic [7:0] nxt_evt_0;
    logic [7:0] nxt_evt_1;
    logic [7:0] set_0;
    logic [7:0] set_1;
    logic [7:0] clr_0;
    logic [7:0] clr_1;
    logic [1:0] rise;
    logic [1:0] fall;
    logic       run_done;

    // ------------------------------------------------------------
    // event sources
    // ------------------------------------------------------------
    efpc_edge_det u_edge (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .level_i   ({loop_locked_i, sync_locked_i}),
        .rise_o    (rise),
        .fall_o    (fall)
    );

    efpc_pat_clear u_pat (
        .clk_sys_i  (clk_sys_i),
        .rstn_i     (rstn_i),
        .pair_ok_i  (pair_ok_i),
        .pair_bad_i (pair_bad_i),
        .run_done_o (run_done)
    );

    always_comb begin
        set_0 = 8'h00;
        set_0[EFPC_B_LOOP_LOST]    = fall[1];
        set_0[EFPC_B_LOOP_LOCK]    = rise[1];
        set_0[EFPC_B_SYNC_LOST]    = fall[0];
        set_0[EFPC_B_SYNC_LOCK]    = rise[0];
        set_0[EFPC_B_FIFO_ALIGNED] = fifo_aligned_i;
        set_0[EFPC_B_FIFO_WARN_1]  = (fifo_distance_i == 2'h1);
        set_0[EFPC_B_FIFO_WARN_2]  = (fifo_distance_i == 2'h2);
        set_1 = 8'h00;
        set_1[EFPC_B_PAT_PASS]     = pair_ok_i;
        set_1[EFPC_B_PAT_FAIL_AC]  = pair_bad_i;
        set_1[EFPC_B_PAT_FAIL_ST]  = pair_bad_i;
    end

    // ------------------------------------------------------------
    // write-one-to-clear, set wins over clear
    // ------------------------------------------------------------
    always_comb begin
        clr_0 = (reg_wr_i && reg_addr_i == EFPC_OFS_EVT_0) ? reg_wdata_i : 8'h00;
        clr_1 = (reg_wr_i && reg_addr_i == EFPC_OFS_EVT_1) ? reg_wdata_i : 8'h00;
        clr_1[EFPC_B_PAT_FAIL_AC] = clr_1[EFPC_B_PAT_FAIL_AC] | run_done;
        nxt_evt_0 = ((evt_0_ff & ~clr_0) | set_0) & EFPC_MSK_EVT_0;
        nxt_evt_1 = ((evt_1_ff & ~clr_1) | set_1) & EFPC_MSK_EVT_1;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            evt_0_ff <= EFPC_RST_EVT;
            evt_1_ff <= EFPC_RST_EVT;
        end else begin
            evt_0_ff <= nxt_evt_0;
            evt_1_ff <= nxt_evt_1;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            irq_en_0_ff <= EFPC_RST_IRQ_EN;
            irq_en_1_ff <= EFPC_RST_IRQ_EN;
            clk_rx_ff   <= EFPC_RST_CLK_RX;
            loop_0_ff   <= EFPC_RST_LOOP_0;
            loop_1_ff   <= EFPC_RST_LOOP_1;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                EFPC_OFS_IRQ_EN_0: irq_en_0_ff <= reg_wdata_i & EFPC_MSK_EVT_0;
                EFPC_OFS_IRQ_EN_1: irq_en_1_ff <= reg_wdata_i & EFPC_MSK_EVT_1;
                // low nibble stored as written; software keeps it at 0111
                EFPC_OFS_CLK_RX:   clk_rx_ff   <= reg_wdata_i;
                EFPC_OFS_LOOP_0:   loop_0_ff   <= reg_wdata_i;
                EFPC_OFS_LOOP_1:   loop_1_ff   <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs and read back
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(evt_0_ff & irq_en_0_ff) | |(evt_1_ff & irq_en_1_ff);
        end
    end

    // read data registered: answer one cycle after the read strobe
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                EFPC_OFS_IRQ_EN_0: rdata_ff <= irq_en_0_ff;
                EFPC_OFS_IRQ_EN_1: rdata_ff <= irq_en_1_ff;
                EFPC_OFS_EVT_0:    rdata_ff <= evt_0_ff;
                EFPC_OFS_EVT_1:    rdata_ff <= evt_1_ff;
                EFPC_OFS_CLK_RX:   rdata_ff <= clk_rx_ff;
                EFPC_OFS_LOOP_0:   rdata_ff <= loop_0_ff;
                EFPC_OFS_LOOP_1:   rdata_ff <= loop_1_ff;
                default:           rdata_ff <= 8'h00;
            endcase
        end
    end

    assign reg_rdata_o           = rdata_ff;
    assign irq_o                 = irq_ff;
    assign clk_duty_corr_o       = clk_rx_ff[EFPC_B_CLK_DUTY];
    assign ref_duty_corr_o       = clk_rx_ff[EFPC_B_REF_DUTY];
    assign clk_cross_corr_o      = clk_rx_ff[EFPC_B_CLK_CROSS];
    assign ref_cross_corr_o      = clk_rx_ff[EFPC_B_REF_CROSS];
    assign clk_rx_trim_o         = clk_rx_ff[3:0];
    assign loop_enable_o         = loop_0_ff[EFPC_B_LOOP_EN];
    assign band_manual_o         = loop_0_ff[EFPC_B_BAND_MANUAL];
    assign loop_oscillator_band_o = loop_0_ff[EFPC_B_BAND_HI:0];
    assign loop_bandwidth_o      = loop_1_ff[EFPC_B_BW_HI:EFPC_B_BW_LO];
    assign loop_trim_o           = loop_1_ff[4:0];

endmodule : efpc_regs

//--- tb/efpc_regs_properties.sv
module efpc_regs_properties (
    // clock and reset
    input wire logic       clk_sys_i,
    input wire logic       rstn_i,
    // register port
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    // sources and results
    input wire logic       loop_locked_i,
    input wire logic [1:0] fifo_distance_i,
    input wire logic       pair_ok_i,
    input wire logic       pair_bad_i,
    input wire logic       clk_duty_corr_o,
    input wire logic       ref_duty_corr_o,
    input wire logic       clk_cross_corr_o,
    input wire logic       ref_cross_corr_o,
    input wire logic [3:0] clk_rx_trim_o,
    input wire logic       loop_enable_o,
    input wire logic       band_manual_o,
    input wire logic [5:0] loop_oscillator_band_o,
    input wire logic [2:0] loop_bandwidth_o,
    input wire logic [4:0] loop_trim_o,
    input wire logic       irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    sequence s_rd(a);
        reg_rd_i && !reg_wr_i && reg_addr_i == a;
    endsequence
    sequence s_wr(a, d);
        reg_wr_i && reg_addr_i == a && reg_wdata_i == d;
    endsequence
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_unmapped_read: assert property (
        reg_rd_i && !(reg_addr_i inside {8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0a, 8'h0c})
        |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    a_rdata_hold: assert property (
        !reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved without read");
    a_clkrx_write: assert property (
        reg_wr_i && reg_addr_i == 8'h08 |=> {clk_duty_corr_o, ref_duty_corr_o, clk_cross_corr_o,
        ref_cross_corr_o, clk_rx_trim_o} == $past(reg_wdata_i)) else $error("clock rx write");
    a_loop0_write: assert property (
        reg_wr_i && reg_addr_i == 8'h0a |=> {loop_enable_o, band_manual_o,
        loop_oscillator_band_o} == $past(reg_wdata_i)) else $error("loop 0 write");
    a_loop1_write: assert property (
        reg_wr_i && reg_addr_i == 8'h0c |=> {loop_bandwidth_o, loop_trim_o} == $past(reg_wdata_i))
        else $error("loop 1 write");
    a_lock_flag: assert property (
        $rose(loop_locked_i) ##1 !reg_wr_i ##1 s_rd(8'h06) |=> reg_rdata_o[6])
        else $error("lock flag missing");
    a_fifo_warn: assert property (
        (fifo_distance_i == 2'h1 && !reg_wr_i) [*2] ##1 s_rd(8'h06) |=> reg_rdata_o[1])
        else $error("fifo warning missing");
    a_pat_autoclear: assert property (
        pair_bad_i ##1 (pair_ok_i && !pair_bad_i && !reg_wr_i) [*8] ##1 s_rd(8'h07)
        |=> reg_rdata_o[3:2] == 2'b01) else $error("pattern fail flags wrong");
    a_irq_off: assert property (
        s_wr(8'h04, 8'h00) ##2 s_wr(8'h05, 8'h00) |=> ##1 !irq_o) else $error("irq not masked");
endmodule : efpc_regs_properties

bind efpc_regs efpc_regs_properties u_efpc_regs_properties (
    .clk_sys_i, .rstn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
    .loop_locked_i, .fifo_distance_i, .pair_ok_i, .pair_bad_i, .clk_duty_corr_o,
    .ref_duty_corr_o, .clk_cross_corr_o, .ref_cross_corr_o, .clk_rx_trim_o, .loop_enable_o,
    .band_manual_o, .loop_oscillator_band_o, .loop_bandwidth_o, .loop_trim_o, .irq_o
);

//--- tb/efpc_regs_tb.sv
module efpc_regs_tb;
    import efpc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------
    logic       clk_sys_i = 1'b0;
    logic       rstn_i = 1'b0;
    logic       reg_wr_i = 1'b0;
    logic       reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic       loop_locked_i = 1'b0;
    logic       sync_locked_i = 1'b0;
    logic       fifo_aligned_i = 1'b0;
    logic [1:0] fifo_distance_i = 2'h0;
    logic       pair_ok_i = 1'b0;
    logic       pair_bad_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic       clk_duty_corr_o, ref_duty_corr_o, clk_cross_corr_o, ref_cross_corr_o;
    logic [3:0] clk_rx_trim_o;
    logic       loop_enable_o, band_manual_o, irq_o;
    logic [5:0] loop_oscillator_band_o;
    logic [2:0] loop_bandwidth_o;
    logic [4:0] loop_trim_o;
    int         fail_count = 0;
    int         n_checks = 0;
    logic [7:0] ofs [8] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0a, 8'h0c, 8'h09};
    logic [7:0] rst [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h37, 8'h40, 8'hd1, 8'h00};

    efpc_regs u_efpc_regs (
        .clk_sys_i, .rstn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
        .loop_locked_i, .sync_locked_i, .fifo_aligned_i, .fifo_distance_i, .pair_ok_i,
        .pair_bad_i, .clk_duty_corr_o, .ref_duty_corr_o, .clk_cross_corr_o, .ref_cross_corr_o,
        .clk_rx_trim_o, .loop_enable_o, .band_manual_o, .loop_oscillator_band_o,
        .loop_bandwidth_o, .loop_trim_o, .irq_o
    );

    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic step(input int n = 1);
        repeat (n) begin
            @(posedge clk_sys_i);
            #1;
        end
    endtask : step
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    // strobes drop and one idle cycle follows, so calls never collide
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        step();
        reg_wr_i = 1'b0;
        step();
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        step();
        reg_rd_i = 1'b0;
        check(reg_rdata_o, exp);
        step();
    endtask : rd
    task automatic ctl(input logic [7:0] c, input logic [7:0] l0, input logic [7:0] l1);
        check({clk_duty_corr_o, ref_duty_corr_o, clk_cross_corr_o, ref_cross_corr_o,
               clk_rx_trim_o}, c);
        check({loop_enable_o, band_manual_o, loop_oscillator_band_o}, l0);
        check({loop_bandwidth_o, loop_trim_o}, l1);
    endtask : ctl
    task automatic pat(input int n);
        pair_bad_i = 1'b1;
        step();
        pair_bad_i = 1'b0;
        pair_ok_i = 1'b1;
        step(n);
        pair_ok_i = 1'b0;
    endtask : pat
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_sys_i);
        #1;
        rstn_i = 1'b1;
        foreach (ofs[i]) rd(ofs[i], rst[i]);
        ctl(8'h37, 8'h40, 8'hd1);
        wr(8'h08, 8'hc7);
        wr(8'h0a, 8'hbf);
        wr(8'h0c, 8'he9);
        wr(8'h0b, 8'hff);
        ctl(8'hc7, 8'hbf, 8'he9);
        rd(8'h0b, 8'h00);
        wr(8'h0c, 8'h09);
        ctl(8'hc7, 8'hbf, 8'h09);
        loop_locked_i = 1'b1;
        step(2);
        rd(8'h06, 8'h40);
        loop_locked_i = 1'b0;
        step(2);
        rd(8'h06, 8'hc0);
        sync_locked_i = 1'b1;
        step(2);
        sync_locked_i = 1'b0;
        step(2);
        rd(8'h06, 8'hf0);
        fifo_aligned_i = 1'b1;
        step();
        fifo_aligned_i = 1'b0;
        step();
        rd(8'h06, 8'hf4);
        fifo_distance_i = 2'h2;
        step();
        fifo_distance_i = 2'h1;
        step(2);
        fifo_distance_i = 2'h0;
        rd(8'h06, 8'hf7);
        wr(8'h06, 8'h00);
        rd(8'h06, 8'hf7);
        wr(8'h06, 8'h81);
        rd(8'h06, 8'h76);
        wr(8'h06, 8'hff);
        rd(8'h06, 8'h00);
        wr(8'h04, 8'h02);
        check(irq_o, 8'h00);
        fifo_distance_i = 2'h1;
        step();
        fifo_distance_i = 2'h0;
        step(2);
        check(irq_o, 8'h01);
        wr(8'h06, 8'h02);
        check(irq_o, 8'h00);
        wr(8'h05, 8'hff);
        rd(8'h05, 8'h1c);
        wr(8'h05, 8'h10);
        pat(7);
        rd(8'h07, 8'h1c);
        check(irq_o, 8'h01);
        pat(8);
        rd(8'h07, 8'h14);
        wr(8'h07, 8'hff);
        rd(8'h07, 8'h00);
        wr(8'h04, 8'h00);
        wr(8'h05, 8'h00);
        check(irq_o, 8'h00);
        // mid-run reset: written controls, enables and flags must all return to defaults
        wr(8'h05, 8'h10);
        pat(1);
        step();
        check(irq_o, 8'h01);
        rstn_i = 1'b0;
        step(2);
        rstn_i = 1'b1;
        check(irq_o, 8'h00);
        ctl(8'h37, 8'h40, 8'hd1);
        rd(8'h07, 8'h00);
        rd(8'h05, 8'h00);
        rd(8'h08, 8'h37);
        conclude();
    end

    initial begin
        repeat (5000) @(posedge clk_sys_i);
        fail_count++;
        conclude();
    end
endmodule : efpc_regs_tb
